// ---- bench/testbench.sv ----
/*
  Self-checking bench for the channel control block: AXI4-Lite master
  tasks, receive FIFO model, directed register sequences.
  Assumes a single 25 MHz clock and synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ucb_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [5:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] rx_count, tx_count = '0;
  logic [2:0] head_err, put_err = '0;
  logic err_push, tx_ser = 1, rts_n = 1, rx_in = 1, tse = 1, rto = 0;
  // pulsed inputs, one bit each; pulse toggles a bit and back
  localparam int P_CTS = 0, P_XOFF = 1, P_XON = 2, P_SPEC = 3;
  localparam int P_PUT = 4, P_POP = 5, P_TXW = 6, P_OVR = 7;
  logic [7:0] pv = 8'h01;
  wire logic cts_n = pv[0], xoff = pv[1], xon = pv[2], spec = pv[3];
  wire logic put = pv[4], pop = pv[5], tx_push = pv[6], ovr = pv[7];
  logic [3:0] modem_in = '0;
  logic tx_out, irq, txreq, rxreq, baud_tick, clk_run, polled_mode;
  logic [7:0] d;
  int error_cnt = 0, total_checks = 0, c;

  always #20 aclk = ~aclk;

  ucb_rx_model rxm (.aclk(aclk), .aresetn(aresetn), .put(put),
    .put_err(put_err), .pop(pop), .count(rx_count),
    .head_err(head_err), .err_push(err_push));

  ucb_ctrl #(.IDLE_LEN(8)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_count(rx_count), .tx_count(tx_count),
    .fifo_depth(7'h40), .tx_shift_empty(tse), .rx_pop(pop),
    .tx_push(tx_push), .rx_head_err(head_err), .rx_err_push(err_push),
    .rx_timeout(rto), .rx_overrun(ovr), .tx_thr_irq(1'b0),
    .msr_irq(1'b0), .xoff_seen(xoff), .xon_seen(xon),
    .special_seen(spec), .rx_in(rx_in), .rts_n_in(rts_n),
    .cts_n_in(cts_n), .modem_in(modem_in), .tx_ser(tx_ser),
    .tx_out(tx_out), .irq(irq), .tx_dma_request(txreq),
    .rx_dma_request(rxreq), .baud_tick(baud_tick), .clk_run(clk_run),
    .polled_mode(polled_mode));

  task chk(input string n, input logic [15:0] seen, input logic [15:0] e);
    total_checks++;
    if (seen !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, seen);
    end
  endtask

  task wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end
    while (!bvalid);
    bready <= 0;
  endtask

  task rd(input logic [5:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end
    while (!rvalid);
    d = rdata[7:0];
    rready <= 0;
  endtask

  task pulse(input int k);
    @(posedge aclk);
    pv[k] <= !pv[k];
    @(posedge aclk);
    pv[k] <= !pv[k];
    repeat (2) @(posedge aclk);
  endtask

  task fc(input logic [1:0] e);
    rd(OFF_STAT);
    chk("flow cause", d[3:2], e);
  endtask

  task gap;
    c = 0;
    do @(posedge aclk); while (!baud_tick);
    do
    begin
      @(posedge aclk);
      c++;
    end
    while (!baud_tick);
  endtask

  task ticks(input int n);
    c = 0;
    repeat (n)
    begin
      @(posedge aclk);
      if (baud_tick) c++;
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    test_done;
  end

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rd(OFF_DLL);
    chk("divisor low", d, RST_DLL);
    chk("polled", polled_mode, 1);
    wr(OFF_IER, 8'h01);
    chk("polled", polled_mode, 0);
    wr(OFF_LCR, 8'h40);
    chk("tx_out", tx_out, 0);
    wr(OFF_LCR, 8'h00);
    chk("tx_out", tx_out, 1);
    $display("test reset and break done");
    @(posedge aclk) pv[P_CTS] <= 1'b0;
    pulse(P_CTS);
    fc(FC_PIN);
    rd(OFF_IIR);
    fc(FC_NONE);
    pulse(P_XOFF);
    fc(FC_XOFF);
    pulse(P_XON);
    fc(FC_NONE);
    pulse(P_SPEC);
    fc(FC_SPEC);
    rd(OFF_LSR);
    fc(FC_NONE);
    $display("test flow causes done");
    wr(OFF_IER, 8'h04);
    pulse(P_OVR);
    chk("irq", irq, 1);
    rd(OFF_LSR);
    chk("overrun", d[1], 1);
    @(posedge aclk);
    chk("irq", irq, 0);
    $display("test irq done");
    put_err <= 3'h0;
    pulse(P_PUT);
    put_err <= 3'h4;
    pulse(P_PUT);
    rd(OFF_LSR);
    chk("err sum", d[7], 1);
    chk("head err", d[4:2], 3'h0);
    chk("rx req", rxreq, 1);
    pulse(P_POP);
    rd(OFF_LSR);
    chk("err sum", d[7], 1);
    chk("head err", d[4:2], 3'h4);
    pulse(P_POP);
    rd(OFF_LSR);
    chk("err sum", d[7], 0);
    chk("head err", d[4:2], 3'h0);
    chk("rx req", rxreq, 0);
    chk("tx req", txreq, 1);
    tx_count <= 7'h01;
    repeat (3) @(posedge aclk);
    chk("tx req", txreq, 0);
    wr(OFF_TRIG, 8'h04);
    wr(OFF_FCR, 8'h09);
    tx_count <= 7'h40;
    repeat (3) @(posedge aclk);
    chk("tx req", txreq, 0);
    tx_count <= 7'h3d;
    repeat (3) @(posedge aclk);
    chk("tx req", txreq, 0);
    tx_count <= 7'h3c;
    repeat (3) @(posedge aclk);
    chk("tx req", txreq, 1);
    put_err <= 3'h0;
    pulse(P_PUT);
    chk("rx req", rxreq, 0);
    rto <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("rx req", rxreq, 1);
    rto <= 1'b0;
    pulse(P_POP);
    chk("rx req", rxreq, 0);
    tx_count <= 7'h00;
    wr(OFF_FCR, 8'h00);
    $display("test errors and dma done");
    wr(OFF_IER, 8'h10);
    repeat (40) @(posedge aclk);
    chk("clk_run", clk_run, 1);
    tse <= 1'b0;
    wr(OFF_EFR, 8'h10);
    repeat (40) @(posedge aclk);
    chk("clk_run", clk_run, 1);
    tse <= 1'b1;
    repeat (40) @(posedge aclk);
    chk("clk_run", clk_run, 0);
    ticks(20);
    chk("ticks asleep", 16'(c), 0);
    // a tx write leaves the fifo non-empty, else sleep resumes at once
    tx_count <= 7'h01;
    pulse(P_TXW);
    chk("clk_run", clk_run, 1);
    wr(OFF_IER, 8'h00);
    tx_count <= 7'h00;
    $display("test sleep done");
    wr(OFF_DLL, 8'h03);
    gap;
    chk("tick gap", 16'(c), 16'h3);
    wr(OFF_MCR, 8'h80);
    gap;
    chk("tick gap", 16'(c), 16'hc);
    wr(OFF_MCR, 8'h00);
    wr(OFF_DLL, 8'h00);
    ticks(40);
    chk("ticks zero div", 16'(c), 0);
    wr(OFF_DLH, 8'h01);
    gap;
    chk("tick gap", 16'(c), 16'h100);
    $display("test baud done");
    test_done;
  end
endmodule
`default_nettype wire

// ---- bench/ucb_rx_model.sv ----
/*
  Receive FIFO stand-in: keeps per-character error bits and reports the
  level, the head character's status and error entries. Assumes the
  bench pulses put and pop for one aclk cycle each.
*/
`timescale 1ns/1ns
`default_nettype none
module ucb_rx_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench side
  input  wire logic       put,
  input  wire logic [2:0] put_err,
  input  wire logic       pop,
  // status toward the design
  output logic [6:0]      count,
  output logic [2:0]      head_err,
  output logic            err_push
);
  logic [2:0] q[$];
  always @(posedge aclk)
  begin
    err_push <= put && (put_err != 3'h0);
    if (!aresetn)
      q = {};
    else
    begin
      if (pop && q.size() > 0)
        void'(q.pop_front());
      if (put)
        q.push_back(put_err);
    end
    count <= 7'(q.size());
    head_err <= (q.size() == 0) ? 3'h0 : q[0];
  end
endmodule
`default_nettype wire

// ---- inc/ucb_pkg.sv ----
/*
  Constants for the UART channel control block: register offsets of the
  AXI4-Lite register file, field positions, reset values, state codes.
  Assumes a single 25 MHz clock domain.
*/
`default_nettype none
package ucb_pkg;
  localparam int ADDR_W = 6;
  // register byte offsets
  localparam logic [5:0] OFF_IER  = 6'h00;
  localparam logic [5:0] OFF_FCR  = 6'h04;
  localparam logic [5:0] OFF_LCR  = 6'h08;
  localparam logic [5:0] OFF_MCR  = 6'h0c;
  localparam logic [5:0] OFF_EFR  = 6'h10;
  localparam logic [5:0] OFF_DLL  = 6'h14;
  localparam logic [5:0] OFF_DLH  = 6'h18;
  localparam logic [5:0] OFF_LSR  = 6'h1c;
  localparam logic [5:0] OFF_IIR  = 6'h20;
  localparam logic [5:0] OFF_STAT = 6'h24;
  localparam logic [5:0] OFF_TRIG = 6'h28;
  // field positions
  localparam int IER_SLEEP = 4;
  localparam int FCR_EN    = 0;
  localparam int FCR_DMA   = 3;
  localparam int LCR_BRK   = 6;
  localparam int MCR_PRE   = 7;
  localparam int EFR_ENH   = 4;
  localparam int LSR_ERR   = 7;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_DLL  = 8'h01;
  // flow-interrupt causes
  localparam logic [1:0] FC_NONE = 2'h0;
  localparam logic [1:0] FC_XOFF = 2'h1;
  localparam logic [1:0] FC_SPEC = 2'h2;
  localparam logic [1:0] FC_PIN  = 2'h3;
  // idle detect: bits per character time, character times
  localparam int IDLE_CHARS = 4;
  localparam int BITS_PER_CH = 10;
  localparam int OS_RATE = 16;
  localparam int IDLE_TICKS = IDLE_CHARS * BITS_PER_CH * OS_RATE;
  localparam int PRE_DIV = 4;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PW_AWAKE = 2'b01,
    PW_SLEEP = 2'b10
  } ucb_pw_t;
endpackage
`default_nettype wire

// ---- src/ucb_ctrl.sv ----
/*
  Channel control for a FIFO-buffered UART: error summary, flow-control
  interrupt causes, interrupt output, DMA ready outputs, sleep, idle and
  break, and the prescaled baud divider. Assumes the FIFOs and shifters
  sit outside and report their state on the ports below, synchronous
  to aclk. Registers are reached over AXI4-Lite.
*/
`timescale 1ns/1ns
`default_nettype none
module ucb_ctrl
  import ucb_pkg::*;
#(
  parameter int FIFO_AW = 7,
  parameter int IDLE_LEN = ucb_pkg::IDLE_TICKS
)(
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // axi4-lite slave
  input  wire logic [5:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [5:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // fifo and shifter status
  input  wire logic [FIFO_AW-1:0] rx_count,
  input  wire logic [FIFO_AW-1:0] tx_count,
  input  wire logic [FIFO_AW-1:0] fifo_depth,
  input  wire logic               tx_shift_empty,
  input  wire logic               rx_pop,
  input  wire logic               tx_push,
  input  wire logic [2:0]         rx_head_err,
  input  wire logic               rx_err_push,
  input  wire logic               rx_timeout,
  input  wire logic               rx_overrun,
  input  wire logic               tx_thr_irq,
  input  wire logic               msr_irq,
  // flow-control events
  input  wire logic               xoff_seen,
  input  wire logic               xon_seen,
  input  wire logic               special_seen,
  // pins
  input  wire logic               rx_in,
  input  wire logic               rts_n_in,
  input  wire logic               cts_n_in,
  input  wire logic [3:0]         modem_in,
  input  wire logic               tx_ser,
  // outputs
  output logic                    tx_out,
  output logic                    irq,
  output logic                    tx_dma_request,
  output logic                    rx_dma_request,
  output logic                    baud_tick,
  output logic                    clk_run,
  output logic                    polled_mode
);
  import ucb_pkg::*;

  logic [7:0] irq_enable_reg, fifo_ctrl_reg, line_ctrl_reg, modem_ctrl_reg;
  logic [7:0] enhanced_feature_reg, divisor_low_byte, divisor_high_byte;
  logic [FIFO_AW-1:0] trig_q;
  ucb_pw_t pw_q;
  logic asleep;
  assign asleep = (pw_q == PW_SLEEP);

  // ---------------- axi4-lite slave ----------------
  logic aw_hold_q, w_hold_q;
  logic [5:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire, rd_fire;
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  function automatic logic known(input logic [5:0] a);
    known = (a <= OFF_TRIG) && (a[1:0] == 2'h0);
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 6'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known(awaddr_q) ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_byte;
  assign wr_byte = wr_fire && wstrb_q[0];

  // control registers; divisor writes while asleep are ignored
  // divisor write guard
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_enable_reg <= RST_BYTE;
      fifo_ctrl_reg <= RST_BYTE;
      line_ctrl_reg <= RST_BYTE;
      modem_ctrl_reg <= RST_BYTE;
      enhanced_feature_reg <= RST_BYTE;
      divisor_low_byte <= RST_DLL;
      divisor_high_byte <= RST_BYTE;
      trig_q <= '0;
    end
    else if (wr_byte)
    begin
      if (awaddr_q == OFF_IER)
        irq_enable_reg <= wdata_q[7:0];
      else if (awaddr_q == OFF_FCR)
        fifo_ctrl_reg <= wdata_q[7:0];
      else if (awaddr_q == OFF_LCR)
        line_ctrl_reg <= wdata_q[7:0];
      // prescaler bit only with enhanced mode
      else if (awaddr_q == OFF_MCR)
        modem_ctrl_reg <= enhanced_feature_reg[EFR_ENH] ? wdata_q[7:0]
          : {modem_ctrl_reg[MCR_PRE], wdata_q[6:0]};
      else if (awaddr_q == OFF_EFR)
        enhanced_feature_reg <= wdata_q[7:0];
      else if (awaddr_q == OFF_DLL && !asleep)
        divisor_low_byte <= wdata_q[7:0];
      else if (awaddr_q == OFF_DLH && !asleep)
        divisor_high_byte <= wdata_q[7:0];
      else if (awaddr_q == OFF_TRIG)
        trig_q <= wdata_q[FIFO_AW-1:0];
    end
  end

  // ---------------- error tracking ----------------
  logic [FIFO_AW-1:0] err_cnt_q;
  logic [2:0] head_err;
  logic err_sum, rx_empty;
  assign rx_empty = (rx_count == '0);
  // count of erroneous characters in fifo
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      err_cnt_q <= '0;
    else if (rx_err_push && !(rx_pop && |rx_head_err))
      err_cnt_q <= err_cnt_q + 1'b1;
    else if (!rx_err_push && rx_pop && |rx_head_err && err_cnt_q != '0)
      err_cnt_q <= err_cnt_q - 1'b1;
  end
  assign err_sum = (err_cnt_q != '0);
  assign head_err = rx_empty ? 3'h0 : rx_head_err;

  // ---------------- read path ----------------
  logic lsr_rd, iir_rd;
  logic [1:0] fc_q;
  logic oe_q;
  logic [7:0] lsr_val;
  logic [3:0] iir_val;
  // summary in bit 7 carries the error interrupt
  assign lsr_val = {err_sum, (tx_count == '0) && tx_shift_empty,
                    tx_count == '0, head_err, oe_q, !rx_empty};
  assign lsr_rd = rd_fire && s_axi_araddr == OFF_LSR;
  assign iir_rd = rd_fire && s_axi_araddr == OFF_IIR;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= known(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
      if (s_axi_araddr == OFF_IER)
        s_axi_rdata <= {24'h0, irq_enable_reg};
      else if (s_axi_araddr == OFF_FCR)
        s_axi_rdata <= {24'h0, fifo_ctrl_reg};
      else if (s_axi_araddr == OFF_LCR)
        s_axi_rdata <= {24'h0, line_ctrl_reg};
      else if (s_axi_araddr == OFF_MCR)
        s_axi_rdata <= {24'h0, modem_ctrl_reg};
      else if (s_axi_araddr == OFF_EFR)
        s_axi_rdata <= {24'h0, enhanced_feature_reg};
      else if (s_axi_araddr == OFF_DLL)
        s_axi_rdata <= {24'h0, divisor_low_byte};
      else if (s_axi_araddr == OFF_DLH)
        s_axi_rdata <= {24'h0, divisor_high_byte};
      else if (s_axi_araddr == OFF_LSR)
        s_axi_rdata <= {24'h0, lsr_val};
      else if (s_axi_araddr == OFF_IIR)
        s_axi_rdata <= {28'h0, iir_val};
      else if (s_axi_araddr == OFF_STAT)
        s_axi_rdata <= {26'h0, polled_mode, asleep, fc_q, rx_dma_request,
                        tx_dma_request};
      else if (s_axi_araddr == OFF_TRIG)
        s_axi_rdata <= {{(32-FIFO_AW){1'b0}}, trig_q};
      else
        s_axi_rdata <= 32'h0000_0000;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // overrun cleared by status read; new overrun wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      oe_q <= 1'b0;
    else if (rx_overrun)
      oe_q <= 1'b1;
    else if (lsr_rd)
      oe_q <= 1'b0;
  end

  // ---------------- flow-control interrupt ----------------
  logic rts_n_q, cts_n_q, pin_rise;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // pins idle high; a low reset value would fake a rise
      rts_n_q <= 1'b1;
      cts_n_q <= 1'b1;
    end
    else
    begin
      rts_n_q <= rts_n_in;
      cts_n_q <= cts_n_in;
    end
  end
  assign pin_rise = (rts_n_in && !rts_n_q) || (cts_n_in && !cts_n_q);

  // new cause always beats a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fc_q <= FC_NONE;
    else if (pin_rise)
      fc_q <= FC_PIN;
    else if (xoff_seen)
      fc_q <= FC_XOFF;
    else if (special_seen)
      fc_q <= FC_SPEC;
    else if (fc_q == FC_PIN && iir_rd)
      fc_q <= FC_NONE;
    else if (fc_q == FC_XOFF && xon_seen)
      fc_q <= FC_NONE;
    else if (fc_q == FC_SPEC && lsr_rd)
      fc_q <= FC_NONE;
  end

  // ---------------- interrupt output ----------------
  logic ls_pend, rx_pend, fc_pend;
  logic [FIFO_AW-1:0] tx_free;
  assign tx_free = fifo_depth - tx_count;
  assign ls_pend = err_sum || oe_q;
  assign rx_pend = rx_timeout || (fifo_ctrl_reg[FCR_EN] ?
                   (rx_count >= trig_q && !rx_empty) : !rx_empty);
  assign fc_pend = (fc_q != FC_NONE);
  assign iir_val = ls_pend ? 4'h6 : rx_timeout ? 4'hc : rx_pend ? 4'h4 :
                   tx_thr_irq ? 4'h2 : msr_irq ? 4'h0 : 4'h1;
  // polled when low enables all zero
  assign polled_mode = (irq_enable_reg[3:0] == 4'h0);
  // held until every enabled source clears
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= (irq_enable_reg[2] && ls_pend) ||
             (irq_enable_reg[0] && rx_pend) ||
             (irq_enable_reg[1] && tx_thr_irq) ||
             (irq_enable_reg[3] && msr_irq) ||
             (!polled_mode && fc_pend);
  end

  // ---------------- dma requests ----------------
  logic blk_mode;
  // mode 1 only with fifo enabled
  assign blk_mode = fifo_ctrl_reg[FCR_EN] && fifo_ctrl_reg[FCR_DMA];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_dma_request <= 1'b0;
      rx_dma_request <= 1'b0;
    end
    else if (!blk_mode)
    begin
      tx_dma_request <= (tx_count == '0);
      // single: ready while a character held
      rx_dma_request <= !rx_empty;
    end
    else
    begin
      // block: set at trigger space, clear when full
      if (tx_free == '0)
        tx_dma_request <= 1'b0;
      else if (tx_free >= trig_q)
        tx_dma_request <= 1'b1;
      // block: set at trigger or timeout, clear empty or error
      if (rx_empty || err_sum)
        rx_dma_request <= 1'b0;
      else if (rx_count >= trig_q || rx_timeout)
        rx_dma_request <= 1'b1;
    end
  end

  // ---------------- idle detection ----------------
  logic [15:0] idle_cnt_q;
  logic rx_idle, rx_q;
  // idle after four character times, sampled on ticks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      idle_cnt_q <= 16'h0000;
    else if (!rx_in)
      idle_cnt_q <= 16'h0000;
    else if (baud_tick && idle_cnt_q != 16'(IDLE_LEN))
      idle_cnt_q <= idle_cnt_q + 16'h0001;
  end
  assign rx_idle = (idle_cnt_q == 16'(IDLE_LEN));

  // ---------------- sleep ----------------
  logic [3:0] modem_q;
  logic wake;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_q <= 1'b1;
      modem_q <= 4'h0;
    end
    else
    begin
      rx_q <= rx_in;
      modem_q <= modem_in;
    end
  end
  assign wake = (rx_in != rx_q) || (modem_in != modem_q) || tx_push;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pw_q <= PW_AWAKE;
    else
      case (pw_q)
        PW_AWAKE:
          if (enhanced_feature_reg[EFR_ENH] && irq_enable_reg[IER_SLEEP] &&
              rx_idle && tx_count == '0 && tx_shift_empty && rx_empty &&
              !ls_pend && !msr_irq && !fc_pend && !wake)
            pw_q <= PW_SLEEP;
        PW_SLEEP:
          if (wake || !irq_enable_reg[IER_SLEEP])
            pw_q <= PW_AWAKE;
        default:
          pw_q <= PW_AWAKE;
      endcase
  end
  // clock gate enable for uart and baud clocks
  assign clk_run = !asleep;

  // ---------------- baud generator ----------------
  logic [1:0] pre_q;
  logic [15:0] div_cnt_q, divisor;
  logic pre_tick;
  assign divisor = {divisor_high_byte, divisor_low_byte};
  always_ff @(posedge aclk)
  begin
    if (!aresetn || asleep)
      pre_q <= 2'h0;
    else
      pre_q <= (pre_q == 2'(PRE_DIV - 1)) ? 2'h0 : pre_q + 2'h1;
  end
  assign pre_tick = !asleep &&
                    (!modem_ctrl_reg[MCR_PRE] || pre_q == 2'(PRE_DIV - 1));
  // divide by divisor for 16x tick
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt_q <= 16'h0000;
      baud_tick <= 1'b0;
    end
    else
    begin
      baud_tick <= 1'b0;
      if (divisor == 16'h0000)
        div_cnt_q <= 16'h0000;
      else if (pre_tick)
      begin
        if (div_cnt_q >= divisor - 16'h0001)
        begin
          div_cnt_q <= 16'h0000;
          baud_tick <= 1'b1;
        end
        else
          div_cnt_q <= div_cnt_q + 16'h0001;
      end
    end
  end

  assign tx_out = line_ctrl_reg[LCR_BRK] ? 1'b0 : tx_ser;

  // ---------------- checks ----------------
  chk_break_low: assert property (@(posedge aclk) disable iff (!aresetn)
    line_ctrl_reg[LCR_BRK] |-> !tx_out)
    else $error("break not driving line low");
  chk_zero_div: assert property (@(posedge aclk) disable iff (!aresetn)
    divisor == 16'h0000 |=> !baud_tick)
    else $error("tick with zero divisor");
  chk_sleep_no_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    asleep && $past(asleep) |-> !baud_tick)
    else $error("baud tick while asleep");
  chk_sleep_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(asleep) |-> $past(enhanced_feature_reg[EFR_ENH]) &&
    $past(rx_empty))
    else $error("sleep without enable");
  chk_wake_event: assert property (@(posedge aclk) disable iff (!aresetn)
    asleep && tx_push |=> !asleep)
    else $error("no wake on tx write");
  chk_err_sum: assert property (@(posedge aclk) disable iff (!aresetn)
    blk_mode && err_sum |=> !rx_dma_request)
    else $error("rx request with error flagged");
  chk_head_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_empty |-> lsr_val[4:2] == 3'h0)
    else $error("error bits with empty fifo");
  chk_single_tx: assert property (@(posedge aclk) disable iff (!aresetn)
    !blk_mode && $stable(blk_mode) && tx_count != '0 |=> !tx_dma_request)
    else $error("tx request with loaded char");
  chk_pin_flow: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_rise |=> fc_q == FC_PIN)
    else $error("flow irq not raised");
  chk_polled_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    polled_mode && $past(polled_mode) && !fc_pend && $past(!fc_pend)
    |-> !irq)
    else $error("irq in polled mode");
  cov_sleep: cover property (@(posedge aclk) $rose(asleep));
  cov_wake: cover property (@(posedge aclk) $fell(asleep));
  cov_blk_rx: cover property (@(posedge aclk) blk_mode && rx_dma_request);
  cov_xon: cover property (@(posedge aclk) fc_q == FC_XOFF && xon_seen);
endmodule
`default_nettype wire
